/* cpx_exception_unit.sv */
// Exception dispatcher, capability register and shadow set selection
// ************************************************************
// What this block does
// - Capability register bit 31 always reads one: second register exists.
// - High kernel and user segment cacheability reset to no-cache code.
// - Kernel segment zero coherency sits in bits 2-0, resets to no-cache.
// - Reserved capability bits read zero; software writes zero there.
// - Custom instruction presence bit 22 reads zero.
// - Bit 21 reads one: only simple byte enables used internally.
// - Bit 20 reads zero: fast multiply/divide unit.
// - Bit 16 reads one: split instruction and data SRAM ports.
// - Little endian bit 15 zero, family 00, revision 001.
// - Bits 9-7 report fixed address mapping code 011.
// - Highest priority pending exception wins in the fixed order.
// - Resets and NMI vector to boot address, set boot and error flags.
// - Debug exceptions vector by probe enable and set their debug bit.
// - Debug break request bit raises a debug interrupt.
// - Unmasked interrupt taken: update priority level, cause code zero.
// - General exceptions vector to base plus 0x180, set exception level.
// - Load misalign records cause 0x04, fetch bus error 0x06.
// - System call records cause 0x08, break records 0x09.
// - Four-bit shadow field per level one to five; 1 is set 1.
// - Low shadow bit gives single vector a shadow set.
// - Per-level shadow fields ignored while multi-vector mode is off.
// - Shadow register bits 3-1 read zero, writes ignored.
// ************************************************************
module cpx_exception_unit
  import cpx_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire cpx_req_t exc_req,
  output cpx_disp_t dispatch,
  output logic simple_byte_enables,
  output logic [31:0] core_capability_config
);

  // ************************************************************
  // Decoding helpers
  // ************************************************************

  // Expand byte enables to a bit mask
  function automatic logic [31:0] lane_mask(input logic [3:0] be);
    logic [31:0] m;
    m = '0;
    for (int i = 0; i < 4; i++) begin
      m[i*8 +: 8] = {8{be[i]}};
    end
    return m;
  endfunction

  // Merge a masked write into a stored value
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] wd,
                                        input logic [31:0] m);
    return (old & ~m) | (wd & m);
  endfunction

  // Fixed priority pick over all pending sources; the loop climbs
  // so the highest pending bit is the last one to overwrite the pick
  function automatic cpx_exc_t pick(input logic [11:0] p);
    cpx_exc_t k;
    k = EXC_NONE;
    for (int i = 0; i < 12; i++) begin
      if (p[i]) begin
        k = cpx_exc_t'(4'(12 - i));
      end
    end
    return k;
  endfunction

  // ************************************************************
  // State
  // ************************************************************
  logic bus_ack;
  logic [31:0] cfg_rw;
  logic [31:0] shadow_sel;
  logic [31:0] ctrl;
  logic [31:0] exception_base;
  logic boot_vector_select;
  logic error_level;
  logic soft_reset_flag;
  logic nmi_flag;
  logic exception_level;
  logic [2:0] interrupt_priority_level;
  logic [4:0] cause_code;
  logic [3:0] debug_bits;
  logic cur_shadow_set;
  logic reset_pending;
  logic probe_enabled;
  logic debug_break_request;
  logic multi_vector_mode;
  logic wr_hit;
  logic [31:0] wmask;
  logic [31:0] status_word;
  logic int_ok;
  logic [11:0] pending;
  cpx_exc_t next_kind;
  logic [31:0] next_vector;
  logic next_shadow;
  logic [3:0] lvl_field;

  assign probe_enabled = ctrl[CTL_PROBE];
  assign debug_break_request = ctrl[CTL_BRK];
  assign multi_vector_mode = ctrl[CTL_MULTI_VECTOR_MODE];
  assign wr_hit = avs_write && bus_ack;
  assign wmask = lane_mask(avs_byteenable);

  // ************************************************************
  // Register bus slave
  // ************************************************************

  // One wait cycle on every access keeps read data registered
  assign avs_waitrequest = (avs_read || avs_write) && !bus_ack;

  // Acknowledge toggles in then out so each access ends cleanly
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      bus_ack <= 1'b0;
    end else begin
      bus_ack <= (avs_read || avs_write) && !bus_ack;
    end
  end

  // Capability word: fixed bits plus the three cacheability fields
  always_comb begin
    core_capability_config = CFG_FIXED |
                             (cfg_rw & CFG_WMASK);
  end
  assign simple_byte_enables = core_capability_config[21];

  // Own status word as seen by software
  always_comb begin
    status_word = '0;
    status_word[ST_BEV] = boot_vector_select;
    status_word[ST_ERL] = error_level;
    status_word[ST_SRF] = soft_reset_flag;
    status_word[ST_NMI] = nmi_flag;
    status_word[ST_EXL] = exception_level;
    status_word[ST_IPL_LSB +: 3] = interrupt_priority_level;
    status_word[ST_CAUSE_LSB +: 5] = cause_code;
    status_word[ST_DBG_LSB +: 4] = debug_bits;
    status_word[ST_SET] = cur_shadow_set;
  end

  // Read data captured in the wait cycle; unmapped reads return zero
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      avs_readdata <= '0;
    end else if (avs_read && !bus_ack) begin
      case (avs_address)
        OFF_CONFIG: avs_readdata <= core_capability_config;
        OFF_SHADOW: avs_readdata <= shadow_sel & SS_WMASK;
        OFF_CTRL: avs_readdata <= ctrl;
        OFF_EXCEPTION_BASE: avs_readdata <= exception_base;
        OFF_STATUS: avs_readdata <= status_word;
        default: avs_readdata <= '0;
      endcase
    end
  end

  // Capability fields: only the cacheability triples take writes
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      cfg_rw <= '0;
      cfg_rw[CFG_K23_LSB +: 3] <= CACHE_NONE;
      cfg_rw[CFG_KU_LSB +: 3] <= CACHE_NONE;
      cfg_rw[CFG_K0_LSB +: 3] <= CACHE_NONE;
    end else if (wr_hit && avs_address == OFF_CONFIG) begin
      cfg_rw <= merge(cfg_rw, avs_writedata, wmask & CFG_WMASK);
    end
  end

  // Shadow select register; unimplemented bits never store
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      shadow_sel <= '0;
    end else if (wr_hit && avs_address == OFF_SHADOW) begin
      shadow_sel <= merge(shadow_sel, avs_writedata, wmask & SS_WMASK);
    end
  end

  // Exception base; low bits stay zero so the offset adds cleanly
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      exception_base <= EXCEPTION_BASE_RESET;
    end else if (wr_hit && avs_address == OFF_EXCEPTION_BASE) begin
      exception_base <= merge(exception_base, avs_writedata,
                              wmask & EXCEPTION_BASE_WMASK);
    end
  end

  // Control: probe enable, break request, multi-vector mode
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      ctrl <= '0;
    end else begin
      if (wr_hit && avs_address == OFF_CTRL) begin
        ctrl[CTL_PROBE] <= wmask[CTL_PROBE] ? avs_writedata[CTL_PROBE]
                                            : ctrl[CTL_PROBE];
        ctrl[CTL_MULTI_VECTOR_MODE] <= wmask[CTL_MULTI_VECTOR_MODE] ? avs_writedata[CTL_MULTI_VECTOR_MODE]
                                          : ctrl[CTL_MULTI_VECTOR_MODE];
      end
      // Break request self-clears once the debug interrupt is taken;
      // a fresh software set in that same cycle is kept
      if (wr_hit && avs_address == OFF_CTRL && wmask[CTL_BRK]) begin
        ctrl[CTL_BRK] <= avs_writedata[CTL_BRK];
      end else if (next_kind == EXC_DEBUG_INTERRUPT) begin
        ctrl[CTL_BRK] <= 1'b0;
      end
    end
  end

  // ************************************************************
  // Exception selection
  // ************************************************************

  // Interrupts wait while an exception or error level is active and
  // must exceed the current level, so a handler is not re-entered
  assign int_ok = exc_req.irq && !exception_level && !error_level &&
                  (exc_req.irq_level > interrupt_priority_level);

  // Pending vector, bit 11 is the highest priority
  always_comb begin
    pending = {reset_pending,
               exc_req.soft_reset,
               exc_req.debug_single_step,
               debug_break_request,
               exc_req.nmi,
               int_ok,
               exc_req.instruction_breakpoint_match,
               exc_req.load_misalign_error,
               exc_req.fetch_bus_error,
               exc_req.sw_debug_breakpoint,
               exc_req.syscall,
               exc_req.break_trap};
    next_kind = pick(pending);
  end

  // Shadow set for the level being accepted
  always_comb begin
    lvl_field = SS_CODE_SET0;
    if (exc_req.irq_level >= 3'd1 && exc_req.irq_level <= 3'(SS_LEVELS)) begin
      lvl_field = shadow_sel[SS_LVL1_LSB + 4 * (exc_req.irq_level - 3'd1)
                             +: 4];
    end
    if (multi_vector_mode) begin
      next_shadow = (lvl_field == SS_CODE_SET1);
    end else begin
      next_shadow = shadow_sel[0];
    end
  end

  // Vector for the chosen exception
  always_comb begin
    case (next_kind)
      EXC_RESET, EXC_SOFT, EXC_NMI: next_vector = VEC_BOOT;
      EXC_DSS, EXC_DEBUG_INTERRUPT, EXC_DIB, EXC_DBP: begin
        next_vector = probe_enabled ? VEC_DBG_PROBE
                                    : VEC_DBG_NOPROBE;
      end
      EXC_INT, EXC_LOAD, EXC_FETCH, EXC_SYS, EXC_BRK: begin
        next_vector = exception_base + VEC_GEN_OFF;
      end
      default: next_vector = '0;
    endcase
  end

  // Reset exception is dispatched in the first cycle after release
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      reset_pending <= 1'b1;
    end else begin
      reset_pending <= 1'b0;
    end
  end

  // Dispatch output to the pipeline, a one-cycle take pulse
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      dispatch <= '0;
    end else begin
      dispatch.take <= (next_kind != EXC_NONE);
      dispatch.kind <= next_kind;
      dispatch.vector <= next_vector;
      dispatch.cause_code <= cause_code;
      dispatch.shadow_set <= cur_shadow_set;
      case (next_kind)
        EXC_INT: dispatch.cause_code <= CAUSE_INT;
        EXC_LOAD: dispatch.cause_code <= CAUSE_LOAD;
        EXC_FETCH: dispatch.cause_code <= CAUSE_FETCH;
        EXC_SYS: dispatch.cause_code <= CAUSE_SYS;
        EXC_BRK: dispatch.cause_code <= CAUSE_BRK;
        default: dispatch.cause_code <= cause_code;
      endcase
      if (next_kind == EXC_INT) begin
        dispatch.shadow_set <= next_shadow;
      end
    end
  end

  // ************************************************************
  // Status flags: hardware set wins over a software clear
  // ************************************************************

  // Boot, error, soft-reset and NMI flags
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      boot_vector_select <= 1'b1;
      error_level <= 1'b1;
      soft_reset_flag <= 1'b0;
      nmi_flag <= 1'b0;
    end else begin
      if (wr_hit && avs_address == OFF_STATUS && wmask[0]) begin
        if (avs_writedata[ST_BEV]) boot_vector_select <= 1'b0;
        if (avs_writedata[ST_ERL]) error_level <= 1'b0;
        if (avs_writedata[ST_SRF]) soft_reset_flag <= 1'b0;
        if (avs_writedata[ST_NMI]) nmi_flag <= 1'b0;
      end
      if (next_kind == EXC_RESET || next_kind == EXC_SOFT ||
          next_kind == EXC_NMI) begin
        boot_vector_select <= 1'b1;
        error_level <= 1'b1;
      end
      if (next_kind == EXC_SOFT) soft_reset_flag <= 1'b1;
      if (next_kind == EXC_NMI) nmi_flag <= 1'b1;
    end
  end

  // Exception level for the general exceptions
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      exception_level <= 1'b0;
    end else if (next_kind == EXC_LOAD || next_kind == EXC_FETCH ||
                 next_kind == EXC_SYS || next_kind == EXC_BRK) begin
      exception_level <= 1'b1;
    end else if (wr_hit && avs_address == OFF_STATUS && wmask[0] &&
                 avs_writedata[ST_EXL]) begin
      exception_level <= 1'b0;
    end
  end

  // Priority level: taken from the accepted interrupt, else software
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      interrupt_priority_level <= '0;
    end else if (next_kind == EXC_INT) begin
      interrupt_priority_level <= exc_req.irq_level;
    end else if (wr_hit && avs_address == OFF_STATUS && wmask[0]) begin
      interrupt_priority_level <= avs_writedata[ST_IPL_LSB +: 3];
    end
  end

  // Recorded cause code and the shadow set now in use
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      cause_code <= '0;
      cur_shadow_set <= 1'b0;
    end else begin
      case (next_kind)
        EXC_INT: cause_code <= CAUSE_INT;
        EXC_LOAD: cause_code <= CAUSE_LOAD;
        EXC_FETCH: cause_code <= CAUSE_FETCH;
        EXC_SYS: cause_code <= CAUSE_SYS;
        EXC_BRK: cause_code <= CAUSE_BRK;
        default: cause_code <= cause_code;
      endcase
      if (next_kind == EXC_INT) begin
        cur_shadow_set <= next_shadow;
      end
    end
  end

  // Debug status bits: single step, interrupt, ibreak, sw breakpoint
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      debug_bits <= '0;
    end else begin
      for (int i = 0; i < 4; i++) begin
        if (wr_hit && avs_address == OFF_STATUS && wmask[ST_DBG_LSB] &&
            avs_writedata[ST_DBG_LSB + i]) begin
          debug_bits[i] <= 1'b0;
        end
      end
      case (next_kind)
        EXC_DSS: debug_bits[0] <= 1'b1;
        EXC_DEBUG_INTERRUPT: debug_bits[1] <= 1'b1;
        EXC_DIB: debug_bits[2] <= 1'b1;
        EXC_DBP: debug_bits[3] <= 1'b1;
        default: ;
      endcase
    end
  end

endmodule

/* cpx_pkg.sv */
// Shared constants, types and register layout for the exception unit
package cpx_pkg;

  // ************************************************************
  // Register offsets (byte addresses on the register bus)
  // ************************************************************
  localparam logic [4:0] OFF_CONFIG = 5'h00;
  localparam logic [4:0] OFF_SHADOW = 5'h04;
  localparam logic [4:0] OFF_CTRL = 5'h08;
  localparam logic [4:0] OFF_EXCEPTION_BASE = 5'h0c;
  localparam logic [4:0] OFF_STATUS = 5'h10;

  // ************************************************************
  // Capability register fields and reset values
  // ************************************************************
  localparam logic [2:0] CACHE_NONE = 3'h2;
  localparam int CFG_K23_LSB = 28;
  localparam int CFG_KU_LSB = 25;
  localparam int CFG_K0_LSB = 0;
  localparam logic [31:0] CFG_FIXED = 32'h8021_0580; // Hardwired bits
  localparam logic [31:0] CFG_WMASK = 32'h7e00_0007; // Writable fields

  // ************************************************************
  // Shadow select register fields
  // ************************************************************
  localparam int SS_LVL1_LSB = 4;
  localparam int SS_LEVELS = 5;
  localparam logic [31:0] SS_WMASK = 32'h00ff_fff1;
  localparam logic [3:0] SS_CODE_SET0 = 4'h0;
  localparam logic [3:0] SS_CODE_SET1 = 4'h1;

  // ************************************************************
  // Control and status register fields
  // ************************************************************
  localparam int CTL_PROBE = 0;
  localparam int CTL_BRK = 1;
  localparam int CTL_MULTI_VECTOR_MODE = 12;
  localparam int ST_BEV = 0;
  localparam int ST_ERL = 1;
  localparam int ST_SRF = 2;
  localparam int ST_NMI = 3;
  localparam int ST_EXL = 4;
  localparam int ST_IPL_LSB = 5;
  localparam int ST_CAUSE_LSB = 8;
  localparam int ST_DBG_LSB = 16;
  localparam int ST_SET = 24;
  localparam logic [31:0] EXCEPTION_BASE_RESET = 32'h8000_0000;
  localparam logic [31:0] EXCEPTION_BASE_WMASK = 32'hffff_f000;

  // ************************************************************
  // Vectors and cause codes
  // ************************************************************
  localparam logic [31:0] VEC_BOOT = 32'hbfc0_0000;
  localparam logic [31:0] VEC_DBG_NOPROBE = 32'hbfc0_0480;
  localparam logic [31:0] VEC_DBG_PROBE = 32'hbfc0_0200;
  localparam logic [31:0] VEC_GEN_OFF = 32'h0000_0180;
  localparam logic [4:0] CAUSE_INT = 5'h00;
  localparam logic [4:0] CAUSE_LOAD = 5'h04;
  localparam logic [4:0] CAUSE_FETCH = 5'h06;
  localparam logic [4:0] CAUSE_SYS = 5'h08;
  localparam logic [4:0] CAUSE_BRK = 5'h09;

  // Exception kinds, highest priority first
  typedef enum logic [3:0] {
    EXC_NONE = 4'b0000,
    EXC_RESET = 4'b0001,
    EXC_SOFT = 4'b0010,
    EXC_DSS = 4'b0011,
    EXC_DEBUG_INTERRUPT = 4'b0100,
    EXC_NMI = 4'b0101,
    EXC_INT = 4'b0110,
    EXC_DIB = 4'b0111,
    EXC_LOAD = 4'b1000,
    EXC_FETCH = 4'b1001,
    EXC_DBP = 4'b1010,
    EXC_SYS = 4'b1011,
    EXC_BRK = 4'b1100
  } cpx_exc_t;

  // Requests from the pipeline and interrupt controller
  typedef struct packed {
    logic soft_reset;
    logic debug_single_step;
    logic nmi;
    logic irq;
    logic [2:0] irq_level;
    logic instruction_breakpoint_match;
    logic load_misalign_error;
    logic fetch_bus_error;
    logic sw_debug_breakpoint;
    logic syscall;
    logic break_trap;
  } cpx_req_t;

  // Dispatch answer to the pipeline
  typedef struct packed {
    logic take;
    logic [3:0] kind;
    logic [31:0] vector;
    logic [4:0] cause_code;
    logic shadow_set;
  } cpx_disp_t;

endpackage

/* cpx_exc_checker.sv */
// Concurrent checks on the exception unit's ports
module cpx_exc_checker
  import cpx_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_writedata,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire cpx_req_t exc_req,
  input wire cpx_disp_t dispatch,
  input wire logic simple_byte_enables,
  input wire logic [31:0] core_capability_config
);
  // ********************
  // Port checks
  // ********************
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (rst);

  logic [31:0] cfg;
  logic hi_src;
  logic mid_src;
  logic any_src;
  // Sources that pre-empt the general exceptions
  assign cfg = core_capability_config;
  assign hi_src = exc_req.soft_reset | exc_req.debug_single_step |
    exc_req.nmi | exc_req.irq | exc_req.instruction_breakpoint_match;
  assign mid_src = exc_req.load_misalign_error | exc_req.fetch_bus_error |
    exc_req.sw_debug_breakpoint;
  // Interrupts are left out: they can be refused by the mask
  assign any_src = (hi_src & ~exc_req.irq) | exc_req.irq & 1'h0 | mid_src |
    exc_req.syscall | exc_req.break_trap;

  chk_cfg_top_one: assert property (cfg[31])
    else $error("capability top bit not one");
  chk_cfg_resv_zero: assert property (cfg[24:23] == 2'h0 &&
    cfg[19:17] == 3'h0 && cfg[6:3] == 4'h0)
    else $error("reserved capability bits not zero");
  chk_cfg_fixed: assert property ((cfg & 32'h81ff_fff8) == 32'h8021_0580)
    else $error("fixed capability bits changed");
  chk_byte_en_cap: assert property (simple_byte_enables && cfg[21] &&
    $stable(simple_byte_enables))
    else $error("byte enable capability lost");
  chk_take_follows: assert property (any_src |=> dispatch.take)
    else $error("pending exception not dispatched");
  chk_sys_cause: assert property (exc_req.syscall && !hi_src && !mid_src
    |=> dispatch.kind == 4'hb && dispatch.cause_code == 5'h08 &&
    dispatch.vector[11:0] == 12'h180)
    else $error("system call dispatch wrong");
  chk_brk_cause: assert property (exc_req.break_trap && !hi_src &&
    !mid_src && !exc_req.syscall |=> dispatch.kind == 4'hc &&
    dispatch.cause_code == 5'h09)
    else $error("break dispatch wrong");
  chk_load_cause: assert property (exc_req.load_misalign_error && !hi_src
    |=> dispatch.kind == 4'h8 && dispatch.cause_code == 5'h04)
    else $error("load misalign dispatch wrong");
  chk_nmi_boot: assert property (exc_req.nmi && !exc_req.soft_reset &&
    !exc_req.debug_single_step |=> dispatch.take &&
    dispatch.vector == 32'hbfc0_0000)
    else $error("nmi not sent to boot vector");
  chk_dbg_vector: assert property (dispatch.take &&
    dispatch.kind inside {4'h3, 4'h4, 4'h7, 4'ha} |->
    dispatch.vector inside {32'hbfc0_0480, 32'hbfc0_0200})
    else $error("debug vector wrong");
  chk_int_cause: assert property (dispatch.take && dispatch.kind == 4'h6
    |-> dispatch.cause_code == 5'h00)
    else $error("interrupt cause not zero");
  chk_bus_answer: assert property ($rose(avs_read || avs_write) |->
    avs_waitrequest ##1 !avs_waitrequest)
    else $error("bus answer not one cycle late");
  chk_unmapped_zero: assert property (avs_read && !avs_waitrequest &&
    avs_address > 5'h10 |-> avs_readdata == 32'h0)
    else $error("unmapped read not zero");

  cover property (dispatch.take && dispatch.kind == 4'h6 && dispatch.shadow_set);
  cover property (dispatch.take && dispatch.vector == 32'hbfc0_0200);
  cover property (avs_read && !avs_waitrequest);
endmodule

bind cpx_exception_unit cpx_exc_checker cpx_exc_checker_inst (
  .sys_clk(sys_clk), .rst(rst), .avs_address(avs_address),
  .avs_read(avs_read), .avs_write(avs_write),
  .avs_byteenable(avs_byteenable), .avs_writedata(avs_writedata),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .exc_req(exc_req), .dispatch(dispatch),
  .simple_byte_enables(simple_byte_enables),
  .core_capability_config(core_capability_config)
);

/* cpx_pipe_model.sv */
// Behavioural pipeline that raises exception requests toward the unit
module cpx_pipe_model
  import cpx_pkg::*;
(
  input wire logic sys_clk,
  output cpx_req_t exc_req
);
  // ********************
  // Request driver
  // ********************
  initial exc_req = '0;

  // One cycle only: a held level would be dispatched a second time
  task automatic pulse(input cpx_req_t r);
    exc_req <= r;
    @(posedge sys_clk);
    exc_req <= '0;
  endtask
endmodule

/* tb_top.sv */
// Self-checking bench for the exception unit
module tb_top import cpx_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  // ********************
  // Bench
  // ********************
  localparam logic [31:0] GEN = 32'h8000_0180;
  localparam logic [31:0] DBG0 = 32'hbfc0_0480;
  localparam logic [31:0] DBG1 = 32'hbfc0_0200;
  localparam logic [31:0] BOOT = 32'hbfc0_0000;
  localparam logic [31:0] GM = 32'h0000_1f10;
  localparam logic [31:0] DM = 32'h000f_0000;
  localparam logic [31:0] IM = 32'h0100_1fe0;
  logic sys_clk = 1'h0;
  logic rst = 1'h1;
  logic [4:0] avs_address = 5'h0;
  logic avs_read = 1'h0;
  logic avs_write = 1'h0;
  logic [3:0] avs_byteenable = 4'h0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  cpx_req_t exc_req;
  cpx_disp_t dispatch;
  logic simple_byte_enables;
  logic [31:0] core_capability_config;
  logic [31:0] rd;
  int fail_count = 0;
  int cmp_count = 0;

  cpx_exception_unit cpx_exception_unit_inst (
    .sys_clk(sys_clk), .rst(rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_byteenable(avs_byteenable), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .exc_req(exc_req), .dispatch(dispatch),
    .simple_byte_enables(simple_byte_enables),
    .core_capability_config(core_capability_config));
  cpx_pipe_model cpx_pipe_model_inst (.sys_clk(sys_clk), .exc_req(exc_req));

  initial forever #50 sys_clk = ~sys_clk;

  task automatic report_and_stop();
    if (fail_count == 0 && cmp_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp,
                       input string s);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: %s got %h want %h", $time, s, got, exp);
    end
  endtask

  // Holds the request until waitrequest is seen low at an edge
  task automatic bus(input logic w, input logic [4:0] a, input logic [3:0] be,
                     input logic [31:0] d);
    int n;
    n = 0;
    avs_address <= a;
    avs_byteenable <= be;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= !w;
    do begin
      @(posedge sys_clk);
      n++;
    end while (avs_waitrequest !== 1'h0 && n < 20);
    rd = avs_readdata;
    if (avs_waitrequest !== 1'h0) begin
      fail_count++;
      $display("wrong value at %0t: bus never answered", $time);
      disable seq;
    end
    avs_write <= 1'h0;
    avs_read <= 1'h0;
    @(posedge sys_clk);
  endtask

  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    bus(1'h1, a, 4'hf, d);
  endtask

  task automatic rdc(input logic [4:0] a, input logic [31:0] e, input string s);
    bus(1'h0, a, 4'h0, 32'h0);
    check(rd, e, s);
  endtask

  // Bounded wait for a dispatch; want 0 means the request must be refused
  task automatic wait_take(input logic want);
    int n;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (dispatch.take !== 1'h1 && n < 4);
    check({31'h0, dispatch.take}, {31'h0, want}, "take");
  endtask

  // Raise a request, check dispatch and status, then clear the status flags
  task automatic exc(input cpx_req_t r, input cpx_exc_t k, input logic [31:0] v,
                     input logic [31:0] st, input logic [31:0] m,
                     input logic sh);
    if (r != '0)
      cpx_pipe_model_inst.pulse(r);
    wait_take(1'h1);
    check({28'h0, dispatch.kind}, {28'h0, k}, "kind");
    check(dispatch.vector, v, "vector");
    if (k == EXC_INT)
      check({31'h0, dispatch.shadow_set}, {31'h0, sh}, "shadow set");
    if (m[8])
      check({27'h0, dispatch.cause_code}, {27'h0, st[12:8]}, "cause");
    bus(1'h0, OFF_STATUS, 4'h0, 32'h0);
    check(rd & m, st, "status");
    bus(1'h1, OFF_STATUS, 4'h5, 32'h000f_001f);
  endtask

  // Request bits: soft dss nmi irq lvl[3] dib load fetch dbp sys brk
  initial begin
    begin : seq
      repeat (10) @(posedge sys_clk);
      rst <= 1'h0;
      exc('0, EXC_RESET, BOOT, 32'h3, 32'h1f, 1'h0);
      rdc(OFF_CONFIG, 32'ha421_0582, "config");
      check(core_capability_config, 32'ha421_0582, "port");
      check({31'h0, simple_byte_enables}, 32'h1, "byte enables");
      wr(OFF_CONFIG, 32'hffff_ffff);
      rdc(OFF_CONFIG, 32'hfe21_0587, "config ones");
      wr(OFF_CONFIG, 32'h0);
      rdc(OFF_CONFIG, 32'h8021_0580, "config zeros");
      wr(OFF_CONFIG, 32'ha421_0582);
      wr(OFF_SHADOW, 32'hffff_ffff);
      rdc(OFF_SHADOW, 32'h00ff_fff1, "shadow");
      wr(5'h18, 32'hffff_ffff);
      rdc(5'h18, 32'h0, "unmapped");
      exc(13'h0003, EXC_SYS, GEN, 32'h0810, GM, 1'h0);
      exc(13'h0001, EXC_BRK, GEN, 32'h0910, GM, 1'h0);
      exc(13'h0018, EXC_LOAD, GEN, 32'h0410, GM, 1'h0);
      exc(13'h000a, EXC_FETCH, GEN, 32'h0610, GM, 1'h0);
      exc(13'h0006, EXC_DBP, DBG0, 32'h8_0000, DM, 1'h0);
      exc(13'h0030, EXC_DIB, DBG0, 32'h4_0000, DM, 1'h0);
      exc(13'h0c00, EXC_DSS, DBG0, 32'h1_0000, DM, 1'h0);
      exc(13'h07e0, EXC_NMI, BOOT, 32'h0b, 32'h0f, 1'h0);
      exc(13'h1800, EXC_SOFT, BOOT, 32'h07, 32'h0f, 1'h0);
      wr(OFF_CTRL, 32'h1);
      exc(13'h0800, EXC_DSS, DBG1, 32'h1_0000, DM, 1'h0);
      exc(13'h0004, EXC_DBP, DBG1, 32'h8_0000, DM, 1'h0);
      wr(OFF_CTRL, 32'h3);
      exc(13'h0000, EXC_DEBUG_INTERRUPT, DBG1, 32'h2_0000, DM, 1'h0);
      wr(OFF_CTRL, 32'h1000);
      wr(OFF_SHADOW, 32'h0000_1000);
      exc(13'h02c0, EXC_INT, GEN, 32'h0100_0060, IM, 1'h1);
      exc(13'h0340, EXC_INT, GEN, 32'h0000_00a0, IM, 1'h0);
      bus(1'h1, OFF_STATUS, 4'h1, 32'h80);
      cpx_pipe_model_inst.pulse(13'h02c0);
      wait_take(1'h0);
      bus(1'h1, OFF_STATUS, 4'h1, 32'h0);
      wr(OFF_CTRL, 32'h0);
      exc(13'h02c0, EXC_INT, GEN, 32'h60, IM, 1'h0);
      wr(OFF_SHADOW, 32'h1);
      exc(13'h02c0, EXC_INT, GEN, 32'h0100_0060, IM, 1'h1);
    end
    report_and_stop();
  end
endmodule
